/* shared/tgu_pkg.sv */
// Shared constants and types for the timer and guard unit.
package tgu_pkg;

  // Register file offsets of the unit on its page.
  localparam logic [7:0] OFS_VEC_CTRL = 8'hf6;
  localparam logic [7:0] OFS_CNT_HI = 8'hf8;
  localparam logic [7:0] OFS_CNT_LO = 8'hf9;
  localparam logic [7:0] OFS_PRESCALE = 8'hfa;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'hfb;
  localparam logic [7:0] OFS_WAIT_CTRL = 8'hfc;

  // Reset values.
  localparam logic [15:0] RST_CNT = 16'hffff;
  localparam logic [7:0] RST_PRESCALE = 8'hff;
  localparam logic [7:0] RST_TIMER_CTRL = 8'h12;
  localparam logic [7:0] RST_WAIT_CTRL = 8'h7f;
  localparam logic [7:0] RST_VEC_CTRL = 8'h06;

  // Field positions.
  localparam int BIT_RUN = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_GUARD_N = 6;
  localparam int BIT_TOP_SEL = 2;
  localparam int BIT_A0_SEL = 1;

  // Core clock divider ahead of the prescaler.
  localparam int CORE_DIV = 4;
  localparam logic [1:0] CORE_DIV_LAST = 2'(CORE_DIV - 1);

  // Refresh sequence written to the low counter byte.
  localparam logic [7:0] REFRESH_FIRST = 8'haa;
  localparam logic [7:0] REFRESH_SECOND = 8'h55;

  // Operating state of the counter.
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01,
    ST_GUARD = 2'b11
  } mode_state_t;

  // Progress through the refresh sequence.
  typedef enum logic [1:0] {
    REF_IDLE = 2'b00,
    REF_ARMED = 2'b01
  } refresh_state_t;

endpackage

/* rtl/prescale_divider.sv */
// Programmable prescaler that divides enable ticks by ratio plus one.
module prescale_divider #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic clear_i,
  input wire logic en_i,
  input wire logic [W-1:0] ratio_i,
  // One-cycle pulse at the end of each division period.
  output logic step_o
);

  logic [W-1:0] cnt_r;

  // Counts ticks down to zero, then reloads the live ratio so a new value acts from the next period.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '1;
      step_o <= 1'b0;
    end else if (clear_i) begin
      cnt_r <= ratio_i;
      step_o <= 1'b0;
    end else if (en_i) begin
      if (cnt_r == '0) begin
        cnt_r <= ratio_i;
        step_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 1'b1;
        step_o <= 1'b0;
      end
    end else begin
      step_o <= 1'b0;
    end
  end

endmodule

/* rtl/timer_guard_unit.sv */
// Timer and guard unit: 16-bit down counter with prescaler, timer and watchdog modes.
//
// How it works
// - A 16-bit down counter fed by an 8-bit programmable prescaler.
// - The counter clock is the core clock divided by four in all modes.
// - Counting starts the cycle after the run bit is set, stops when cleared.
// - A restart resumes the held count, or loads a constant written while stopped.
// - Constants written while running apply at end of count; prescaler at the end of its current period.
// - End of count is detected when the counter value is zero.
// - Single mode stops at end of count, reloads and clears the run bit.
// - Continuous mode reloads at each end of count and keeps counting.
// - The mode bit is writable anytime, together with the run bit.
// - Clearing the active-low guard enable enters watchdog mode until reset.
// - Entering watchdog mode starts counting; the run bit then has no effect.
// - In watchdog mode only the prescaler may change, never the constant.
// - In watchdog mode end of count raises a system reset request.
// - In watchdog mode, writing AAh then 55h to the low byte reloads and restarts the count.
// - In watchdog mode counting continues, continuous, whatever run and mode say.
// - In timer mode each end of count raises an enabled interrupt.
// - Two select bits route end of count or pins to each interrupt.
// - In watchdog mode an unrouted slot only serves as a software trap.
// - With both selects zero only the channel A0 interrupt gets end of count.
// - A watchdog-caused reset sets the guard reset flag.
// - The live count is readable at any time, the constant writable outside watchdog mode.
// - The prescaler divides by its value plus one.
// - Control holds run at bit 7, single at bit 6, resets to 12h.
// - Guard enable sits at bit 6 of wait control; reset leaves it disabled.
// - Top-level select zero takes end of count when the A0 select is one; one takes the pin.
module timer_guard_unit (
  // Clock and resets.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_rst_i,
  // Register file port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  output logic [7:0] reg_rdata_o,
  // Pins from outside the clock domain.
  input wire logic guard_enable_strap_i,
  input wire logic ext_irq_pin_zero_i,
  input wire logic nmi_pin_i,
  // Flag clear from the clock flag register.
  input wire logic flag_clear_i,
  // Interrupt and reset requests, guard reset flag and mode indication.
  output logic top_level_irq_o,
  output logic channel_a0_irq_o,
  output logic sys_reset_req_o,
  output logic guard_reset_flag_o,
  output logic guard_mode_o
);

  tgu_pkg::mode_state_t state_r, state_nxt;
  tgu_pkg::refresh_state_t ref_r;
  logic [1:0] div_r;
  logic [15:0] cnt_r, const_r;
  logic [7:0] prescaler_value_r, vec_r;
  logic [2:0] sync1_r, sync2_r, sync3_r, filt_r;
  logic pend_r, run_r, single_r, guard_n_r;
  logic tick, counting, load_start, step_raw, step, eoc;
  logic wr_hi, wr_lo, wr_pre, wr_ctl, wr_wait, wr_vec;
  logic refresh_ok, guard_mode, timer_mode, strap_hw, pin_s, nmi_s;

  // Address decode shared by all write strobes.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  assign wr_hi = reg_wr_i && hit(reg_addr_i, tgu_pkg::OFS_CNT_HI);
  assign wr_lo = reg_wr_i && hit(reg_addr_i, tgu_pkg::OFS_CNT_LO);
  assign wr_pre = reg_wr_i && hit(reg_addr_i, tgu_pkg::OFS_PRESCALE);
  assign wr_ctl = reg_wr_i && hit(reg_addr_i, tgu_pkg::OFS_TIMER_CTRL);
  assign wr_wait = reg_wr_i && hit(reg_addr_i, tgu_pkg::OFS_WAIT_CTRL);
  assign wr_vec = reg_wr_i && hit(reg_addr_i, tgu_pkg::OFS_VEC_CTRL);

  // Pins pass three flops; a level is taken once the last two agree.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sync3_r <= 3'h7;
      filt_r <= 3'h7;
    end else begin
      sync1_r <= {nmi_pin_i, ext_irq_pin_zero_i, guard_enable_strap_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 3; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          filt_r[i] <= sync3_r[i];
        end
      end
    end
  end

  assign strap_hw = !filt_r[0];
  assign pin_s = filt_r[1];
  assign nmi_s = filt_r[2];
  assign guard_mode = !guard_n_r;

  // Free-running divide by four of the core clock.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign tick = div_r == tgu_pkg::CORE_DIV_LAST;

  // Mode state follows the run and guard bits one cycle later.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tgu_pkg::ST_STOP: begin
        if (guard_mode) begin
          state_nxt = tgu_pkg::ST_GUARD;
        end else if (run_r) begin
          state_nxt = tgu_pkg::ST_RUN;
        end
      end
      tgu_pkg::ST_RUN: begin
        if (guard_mode) begin
          state_nxt = tgu_pkg::ST_GUARD;
        end else if (!run_r) begin
          state_nxt = tgu_pkg::ST_STOP;
        end
      end
      tgu_pkg::ST_GUARD: state_nxt = tgu_pkg::ST_GUARD;
      default: state_nxt = tgu_pkg::ST_STOP;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= tgu_pkg::ST_STOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign counting = state_r != tgu_pkg::ST_STOP;
  assign timer_mode = state_r != tgu_pkg::ST_GUARD;
  assign load_start = (state_r == tgu_pkg::ST_STOP) && (state_nxt != tgu_pkg::ST_STOP);

  // The prescaler restarts its period on a start or a refresh.
  prescale_divider #(.W(8)) u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(load_start || refresh_ok),
    .en_i(tick && counting),
    .ratio_i(prescaler_value_r),
    .step_o(step_raw)
  );

  assign step = step_raw && counting;
  assign eoc = step && (cnt_r == 16'h0000);

  // Refresh sequence tracker on low-byte writes.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_r <= tgu_pkg::REF_IDLE;
    end else if (wr_lo) begin
      ref_r <= (reg_wdata_i == tgu_pkg::REFRESH_FIRST) ? tgu_pkg::REF_ARMED : tgu_pkg::REF_IDLE;
    end
  end

  assign refresh_ok = wr_lo && guard_mode && (ref_r == tgu_pkg::REF_ARMED) &&
                      (reg_wdata_i == tgu_pkg::REFRESH_SECOND);

  // Constant registers; locked once the guard is active.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      const_r <= tgu_pkg::RST_CNT;
      pend_r <= 1'b0;
    end else begin
      if (wr_hi && !guard_mode) begin
        const_r[15:8] <= reg_wdata_i;
      end
      if (wr_lo && !guard_mode) begin
        const_r[7:0] <= reg_wdata_i;
      end
      if ((wr_hi || wr_lo) && !guard_mode && !counting) begin
        pend_r <= 1'b1;
      end else if (load_start) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Live counter: start load, refresh reload, decrement and end-of-count reload.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= tgu_pkg::RST_CNT;
    end else if ((load_start && pend_r) || refresh_ok) begin
      cnt_r <= const_r;
    end else if (eoc) begin
      cnt_r <= const_r;
    end else if (step) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // Prescaler value is taken at once, even while counting.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prescaler_value_r <= tgu_pkg::RST_PRESCALE;
    end else if (wr_pre) begin
      prescaler_value_r <= reg_wdata_i;
    end
  end

  // Control bits; single mode clears run at end of count unless software sets it now.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r <= tgu_pkg::RST_TIMER_CTRL[tgu_pkg::BIT_RUN];
      single_r <= tgu_pkg::RST_TIMER_CTRL[tgu_pkg::BIT_SINGLE];
    end else begin
      if (wr_ctl) begin
        single_r <= reg_wdata_i[tgu_pkg::BIT_SINGLE];
        run_r <= reg_wdata_i[tgu_pkg::BIT_RUN];
      end else if (eoc && single_r && state_r == tgu_pkg::ST_RUN) begin
        run_r <= 1'b0;
      end
    end
  end

  // Guard enable: cleared by software or by the strap, set again only by reset.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      guard_n_r <= tgu_pkg::RST_WAIT_CTRL[tgu_pkg::BIT_GUARD_N];
    end else if (strap_hw || (wr_wait && !reg_wdata_i[tgu_pkg::BIT_GUARD_N])) begin
      guard_n_r <= 1'b0;
    end
  end

  // Interrupt vector control register with the two routing selects.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_r <= tgu_pkg::RST_VEC_CTRL;
    end else if (wr_vec) begin
      vec_r <= reg_wdata_i;
    end
  end

  // Interrupt routing; in watchdog mode an unrouted slot stays quiet for software traps.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      top_level_irq_o <= 1'b0;
      channel_a0_irq_o <= 1'b0;
    end else begin
      top_level_irq_o <= vec_r[tgu_pkg::BIT_TOP_SEL] ? nmi_s :
        (timer_mode && vec_r[tgu_pkg::BIT_A0_SEL] && eoc);
      channel_a0_irq_o <= vec_r[tgu_pkg::BIT_A0_SEL] ? pin_s :
        (timer_mode && eoc);
    end
  end

  // Watchdog expiry holds a reset request until the system reset arrives.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_req_o <= 1'b0;
    end else if (eoc && !timer_mode) begin
      sys_reset_req_o <= 1'b1;
    end
  end

  // The cause flag survives the system reset it triggers; set wins over clear.
  always_ff @(posedge clk_i or posedge por_rst_i) begin
    if (por_rst_i) begin
      guard_reset_flag_o <= 1'b0;
    end else if (eoc && !timer_mode) begin
      guard_reset_flag_o <= 1'b1;
    end else if (flag_clear_i) begin
      guard_reset_flag_o <= 1'b0;
    end
  end

  // Mode indication and registered read data.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      guard_mode_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      guard_mode_o <= guard_mode;
      case (reg_addr_i)
        tgu_pkg::OFS_CNT_HI: reg_rdata_o <= cnt_r[15:8];
        tgu_pkg::OFS_CNT_LO: reg_rdata_o <= cnt_r[7:0];
        tgu_pkg::OFS_PRESCALE: reg_rdata_o <= prescaler_value_r;
        tgu_pkg::OFS_TIMER_CTRL: reg_rdata_o <= {run_r, single_r, tgu_pkg::RST_TIMER_CTRL[5:0]};
        tgu_pkg::OFS_WAIT_CTRL: reg_rdata_o <= {1'b0, guard_n_r, tgu_pkg::RST_WAIT_CTRL[5:0]};
        tgu_pkg::OFS_VEC_CTRL: reg_rdata_o <= vec_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Checks on the counter and its outputs.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_single_stop: assert property (
    (eoc && single_r && state_r == tgu_pkg::ST_RUN && !wr_ctl) |=> !run_r)
    else $error("single mode did not clear run at end of count");
  chk_eoc_reload: assert property ((eoc && !refresh_ok) |=> cnt_r == $past(const_r))
    else $error("end of count did not reload the constant");
  chk_decrement: assert property (
    (step && !eoc && !refresh_ok && !load_start) |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("counter did not step down by one");
  chk_guard_sticky: assert property (!guard_n_r |=> !guard_n_r)
    else $error("guard enable was set again");
  chk_guard_reset: assert property (
    (eoc && state_r == tgu_pkg::ST_GUARD) |=> sys_reset_req_o && guard_reset_flag_o)
    else $error("watchdog expiry gave no reset request");
  chk_refresh_reload: assert property (refresh_ok |=> cnt_r == $past(const_r))
    else $error("refresh did not reload the counter");
  chk_const_locked: assert property (
    (state_r == tgu_pkg::ST_GUARD) |=> $stable(const_r))
    else $error("constant changed in watchdog mode");
  chk_stop_hold: assert property (
    (state_r == tgu_pkg::ST_STOP && !load_start) |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  chk_step_spacing: assert property (step_raw |=> !step_raw [*3])
    else $error("prescaler stepped faster than clock divided by four");
  chk_a0_route: assert property (
    (timer_mode && !vec_r[tgu_pkg::BIT_A0_SEL] && eoc) |=> channel_a0_irq_o)
    else $error("end of count missed channel A0");
  chk_tl_both_zero: assert property (
    (!vec_r[tgu_pkg::BIT_A0_SEL] && !vec_r[tgu_pkg::BIT_TOP_SEL]) |=> !top_level_irq_o)
    else $error("top level fired with both selects zero");

  cov_guard_expiry: cover property (eoc && state_r == tgu_pkg::ST_GUARD);
  cov_refresh: cover property (refresh_ok);
  cov_single_eoc: cover property (eoc && single_r && state_r == tgu_pkg::ST_RUN);
  cov_cont_eoc: cover property (eoc && !single_r && state_r == tgu_pkg::ST_RUN);

endmodule

/* tb/testbench.sv */
// Self-checking testbench for the timer and guard unit.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, rst_i, por_rst_i, reg_wr_i, guard_enable_strap_i;
  logic ext_irq_pin_zero_i, nmi_pin_i, flag_clear_i, rd_flag, rd_d;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic top_level_irq_o, channel_a0_irq_o, sys_reset_req_o, guard_reset_flag_o, guard_mode_o;
  int miscompares, total_checks, seed, cyc, top_cnt, n, pr, cv, c2, t0;
  int a0_times[$];
  logic [15:0] exp_q[$];
  logic [7:0] rst_addr[7] = '{8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hf6, 8'h10};
  logic [7:0] rst_val[7] = '{8'hff, 8'hff, 8'hff, 8'h12, 8'h7f, 8'h06, 8'h00};

  timer_guard_unit u_timer_guard_unit (
    .clk_i(clk_i), .rst_i(rst_i), .por_rst_i(por_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rdata_o(reg_rdata_o), .guard_enable_strap_i(guard_enable_strap_i),
    .ext_irq_pin_zero_i(ext_irq_pin_zero_i), .nmi_pin_i(nmi_pin_i),
    .flag_clear_i(flag_clear_i), .top_level_irq_o(top_level_irq_o),
    .channel_a0_irq_o(channel_a0_irq_o), .sys_reset_req_o(sys_reset_req_o),
    .guard_reset_flag_o(guard_reset_flag_o), .guard_mode_o(guard_mode_o)
  );

  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Compares one value and counts the result.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One register write; the strobe drops on the following edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // One register read; the expected masked value waits in the queue.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_i);
    reg_addr_i <= a;
    rd_flag <= 1'b1;
    exp_q.push_back({m, e & m});
    @(posedge clk_i);
    rd_flag <= 1'b0;
  endtask

  // Waits, with a bound, until k end-of-count pulses on channel A0 were seen.
  task automatic wait_a0(input int k);
    for (int i = 0; i < 3000 && a0_times.size() < k; i++) @(posedge clk_i);
  endtask

  // Cycle count and the delayed read marker.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rd_d <= rd_flag;
  end

  // Output watcher: read data is settled by the falling edge after it is registered.
  always @(negedge clk_i) begin
    logic [15:0] ent;
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      check(reg_rdata_o & ent[15:8], ent[7:0]);
    end
    if (channel_a0_irq_o === 1'b1) a0_times.push_back(cyc);
    if (top_level_irq_o === 1'b1) top_cnt++;
  end

  // Cuts a hung run short.
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    conclude();
  end

  // Main sequence.
  initial begin
    seed = 53233;
    miscompares = 0;
    total_checks = 0;
    cyc = 0;
    top_cnt = 0;
    rst_i = 1'b1;
    por_rst_i = 1'b1;
    reg_wr_i = 1'b0;
    rd_flag = 1'b0;
    rd_d = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    guard_enable_strap_i = 1'b1;
    ext_irq_pin_zero_i = 1'b0;
    nmi_pin_i = 1'b0;
    flag_clear_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    por_rst_i <= 1'b0;
    // Reset values, and an unmapped address reading zero.
    for (int i = 0; i < 7; i++) rd(rst_addr[i], rst_val[i], 8'hff);
    // Continuous mode with random ratio and constant; period is exact.
    pr = $random(seed) & 3;
    cv = ($random(seed) & 7) + 1;
    c2 = cv + 8;
    wr(8'hf6, 8'h00);
    // Pins read high for a few cycles after reset; forget the pulses they caused.
    top_cnt = 0;
    a0_times.delete();
    wr(8'hfa, 8'(pr));
    wr(8'hf8, 8'h00);
    wr(8'hf9, 8'(cv));
    wr(8'hfb, 8'h92);
    wait_a0(3);
    check(a0_times[2] - a0_times[1], 4 * (pr + 1) * (cv + 1));
    // A constant written while running waits for the next end of count.
    wr(8'hf9, 8'(c2));
    wait_a0(5);
    check(a0_times[3] - a0_times[2], 4 * (pr + 1) * (cv + 1));
    check(a0_times[4] - a0_times[3], 4 * (pr + 1) * (c2 + 1));
    check(top_cnt, 0);
    // Stopping halts the count.
    wr(8'hfb, 8'h12);
    rd(8'hfb, 8'h00, 8'hc0);
    n = a0_times.size();
    repeat (200) @(posedge clk_i);
    check(a0_times.size(), n);
    // Constant written while stopped, then single mode and run in one write.
    wr(8'hf9, 8'h03);
    wr(8'hfb, 8'hd2);
    wait_a0(n + 1);
    repeat (3) @(posedge clk_i);
    rd(8'hfb, 8'h40, 8'hc0);
    rd(8'hf9, 8'h03, 8'hff);
    rd(8'hf8, 8'h00, 8'hff);
    repeat (200) @(posedge clk_i);
    check(a0_times.size(), n + 1);
    // Pin routing through the two select bits.
    wr(8'hf6, 8'h04);
    nmi_pin_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(top_level_irq_o, 1'b1);
    nmi_pin_i <= 1'b0;
    wr(8'hf6, 8'h02);
    ext_irq_pin_zero_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(channel_a0_irq_o, 1'b1);
    ext_irq_pin_zero_i <= 1'b0;
    // Timer end of count on the top-level request.
    n = top_cnt;
    wr(8'hfb, 8'h92);
    for (int i = 0; i < 500 && top_cnt == n; i++) @(posedge clk_i);
    check(top_cnt > n, 1);
    wr(8'hfb, 8'h12);
    // Watchdog entry; refresh at once since the constant loaded on entry may be short.
    wr(8'hfa, 8'h00);
    wr(8'hf9, 8'h09);
    wr(8'hfc, 8'h3f);
    wr(8'hf9, 8'haa);
    wr(8'hf9, 8'h55);
    check(guard_mode_o, 1'b1);
    wr(8'hfc, 8'h7f);
    rd(8'hfc, 8'h00, 8'h40);
    wr(8'hfb, 8'h40);
    wr(8'hf8, 8'h7f);
    for (int i = 0; i < 6; i++) begin
      wr(8'hf9, 8'haa);
      wr(8'hf9, 8'h55);
      repeat (24) @(posedge clk_i);
    end
    check(sys_reset_req_o, 1'b0);
    wr(8'hf9, 8'haa);
    wr(8'hf9, 8'h55);
    t0 = cyc;
    for (int i = 0; i < 400 && sys_reset_req_o !== 1'b1; i++) @(posedge clk_i);
    check((cyc - t0) >= 36 && (cyc - t0) <= 46, 1);
    check(guard_reset_flag_o, 1'b1);
    // System reset leaves watchdog mode; the flag survives until cleared.
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(guard_mode_o, 1'b0);
    check(guard_reset_flag_o, 1'b1);
    rd(8'hfc, 8'h7f, 8'hff);
    flag_clear_i <= 1'b1;
    @(posedge clk_i);
    flag_clear_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(guard_reset_flag_o, 1'b0);
    // Hardware enable by the strap, with the reset values as time base.
    guard_enable_strap_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(guard_mode_o, 1'b1);
    rd(8'hf8, 8'hff, 8'hff);
    repeat (3) @(posedge clk_i);
    conclude();
  end
endmodule
